// *** hdl/dsc_pkg.sv ***
`default_nettype none

package dsc_pkg;

   localparam logic [6:0] REG_SYNC_CFG = 7'h02;
   localparam logic [6:0] REG_POWER = 7'h03;
   localparam logic [6:0] REG_GAIN = 7'h04;
   localparam logic [6:0] REG_KICK = 7'h05;
   localparam logic [6:0] REG_CODE_A = 7'h08;
   localparam logic [6:0] REG_CODE_B = 7'h09;

   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam logic [4:0] FRAME_LAST = 5'h17;
   localparam int RW_BIT = 23;
   localparam int ADDR_HI = 22;
   localparam int ADDR_LO = 16;
   localparam int DATA_HI = 15;

   localparam int SYNC_EN_BIT = 0;
   localparam int PWR_OUT_A_BIT = 0;
   localparam int PWR_OUT_B_BIT = 1;
   localparam int PWR_REF_BIT = 8;
   localparam int GAIN_AMP_A_BIT = 0;
   localparam int GAIN_AMP_B_BIT = 1;
   localparam int GAIN_DIV_BIT = 8;
   localparam int KICK_LOAD_BIT = 4;
   localparam logic [15:0] SOFT_RESET_KEY = 16'h1010;

   localparam logic [15:0] SYNC_CFG_RST = 16'h0000;
   localparam logic [15:0] POWER_RST = 16'h0000;
   localparam logic [15:0] GAIN_RST = 16'h0003;
   localparam logic [15:0] ZERO_CODE = 16'h0000;
   localparam logic [15:0] MID_CODE = 16'h8000;
   localparam logic [15:0] READ_NONE = 16'h0000;

   // Synchroniser idle image: frame select high, all else low
   localparam logic [4:0] SYNC_IDLE = 5'h10;

   localparam int POR_DELAY_US = 250;
   localparam int CLK_FREQ_KHZ = 10000;
   localparam int POR_CYCLES = (POR_DELAY_US * CLK_FREQ_KHZ + 999) / 1000;
   localparam logic [11:0] POR_CNT_RST = 12'h000;
   localparam logic [11:0] POR_CNT_STEP = 12'h001;

   typedef enum logic [0:0] {
      DSC_BOOT = 1'b0,
      DSC_RUN = 1'b1
   } dsc_state_t;

   // Clear the bits below the converter resolution
   function automatic logic [15:0] dsc_trim(input logic [15:0] d,
                                            input int res);
      logic [15:0] m;
      m = 16'hffff << (16 - res);
      return d & m;
   endfunction : dsc_trim

endpackage : dsc_pkg

`default_nettype wire

// *** hdl/dsc_dual_dac_ctl.sv ***
`default_nettype none

module dsc_dual_dac_ctl
   import dsc_pkg::*;
#(
   parameter int RES_BITS = 16
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic sclk_i,
   input wire logic frame_sel_b_i,
   input wire logic serial_data_in_i,
   input wire logic reset_level_select_i,
   input wire logic interface_select_i,
   input wire logic ref_over_range_i,
   input wire logic i2c_wr_strobe_i,
   input wire logic [23:0] i2c_wr_word_i,
   output logic [15:0] out_code_a_o,
   output logic [15:0] out_code_b_o,
   output logic [1:0] output_amp_double_o,
   output logic ref_halve_o,
   output logic reference_off_o,
   output logic [1:0] out_power_down_o,
   output logic ref_alarm_o,
   output logic init_busy_o,
   output logic iface_i2c_o,
   output logic [15:0] rd_data_o,
   output logic rd_valid_o
);

   localparam logic [11:0] POR_LAST = 12'(POR_CYCLES - 1);

   // Link domain, clocked by the serial clock
   logic [4:0] bit_cnt;
   logic [23:0] shift;
   logic [23:0] link_word;
   logic done_tgl;
   wire link_rst_b;

   // Reference clock domain
   logic [4:0] sync_meta;
   logic [4:0] sync_q;
   logic tgl_prev;
   logic pending;
   dsc_state_t state;
   logic [11:0] por_cnt;
   logic iface_taken;
   logic iface_i2c;
   logic [15:0] sync_cfg;
   logic [15:0] power_setup_reg;
   logic [15:0] amplification_ctl_reg;
   logic [15:0] buf_a;
   logic [15:0] buf_b;
   logic [15:0] active_a;
   logic [15:0] active_b;

   // Frame select high clears the shifter at once, so a short frame
   // leaves nothing behind; the combined reset is glitch tolerant
   // because either source only ever clears
   assign link_rst_b = rst_b_i & ~frame_sel_b_i;

   always_ff @(negedge sclk_i or negedge link_rst_b) begin
      if (!link_rst_b) begin
         bit_cnt <= 5'h00;
         shift <= 24'h000000;
      end else if (bit_cnt != FRAME_BITS) begin
         shift <= {shift[22:0], serial_data_in_i};
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   // Word is held until the next full frame, long after it crosses
   always_ff @(negedge sclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         link_word <= 24'h000000;
         done_tgl <= 1'b0;
      end else if (!frame_sel_b_i && bit_cnt == FRAME_LAST) begin
         link_word <= {shift[22:0], serial_data_in_i};
         done_tgl <= ~done_tgl;
      end
   end

   // Two-flop synchronisers for pins and the frame-done toggle
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_meta <= SYNC_IDLE;
         sync_q <= SYNC_IDLE;
      end else begin
         sync_meta <= {frame_sel_b_i, done_tgl, reset_level_select_i,
                       interface_select_i, ref_over_range_i};
         sync_q <= sync_meta;
      end
   end

   wire fs_high = sync_q[4];
   wire tgl_s = sync_q[3];
   wire rsel_s = sync_q[2];
   wire ifsel_s = sync_q[1];
   wire over_s = sync_q[0];
   wire tgl_evt = tgl_s ^ tgl_prev;
   wire running = (state == DSC_RUN);

   // A complete frame is committed only once frame select is back high
   wire commit_spi = pending & fs_high & running & ~iface_i2c;
   wire commit_i2c = i2c_wr_strobe_i & running & iface_i2c;
   wire commit = commit_spi | commit_i2c;
   wire [23:0] cmd = commit_i2c ? i2c_wr_word_i : link_word;
   wire wr = commit & ~cmd[RW_BIT];
   wire rd = commit & cmd[RW_BIT];
   wire [6:0] addr = cmd[ADDR_HI:ADDR_LO];
   wire [15:0] wdata = cmd[DATA_HI:0];
   wire [15:0] wcode = dsc_trim(wdata, RES_BITS);

   wire hit_sync = (addr == REG_SYNC_CFG);
   wire hit_power = (addr == REG_POWER);
   wire hit_gain = (addr == REG_GAIN);
   wire hit_kick = (addr == REG_KICK);
   wire hit_code_a = (addr == REG_CODE_A);
   wire hit_code_b = (addr == REG_CODE_B);

   wire soft_rst = wr & hit_kick & (wdata == SOFT_RESET_KEY);
   wire load_kick = wr & hit_kick & ~soft_rst &
                    wdata[KICK_LOAD_BIT];
   wire deferred = sync_cfg[SYNC_EN_BIT];
   wire wr_a = wr & hit_code_a;
   wire wr_b = wr & hit_code_b;
   wire [15:0] reset_code = rsel_s ? MID_CODE : ZERO_CODE;
   wire [15:0] reset_trim = dsc_trim(reset_code, RES_BITS);

   // Divider left at 1 while the reference is too high for the supply
   wire alarm = over_s & ~amplification_ctl_reg[GAIN_DIV_BIT];

   wire [15:0] rd_mux = hit_code_a ? buf_a :
                        hit_code_b ? buf_b :
                        hit_sync ? sync_cfg :
                        hit_power ? power_setup_reg :
                        hit_gain ? amplification_ctl_reg :
                        READ_NONE;

   // Frame-done tracking; a new completion wins over a commit clear
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tgl_prev <= 1'b0;
         pending <= 1'b0;
      end else begin
         tgl_prev <= tgl_s;
         pending <= tgl_evt | (pending & ~commit_spi & running);
      end
   end

   // Boot window after power-on or key reset; traffic is ignored in it
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= DSC_BOOT;
         por_cnt <= POR_CNT_RST;
      end else begin
         case (state)
            DSC_BOOT: begin
               por_cnt <= por_cnt + POR_CNT_STEP;
               if (por_cnt == POR_LAST) begin
                  state <= DSC_RUN;
               end
            end
            DSC_RUN: begin
               por_cnt <= POR_CNT_RST;
               if (soft_rst) begin
                  state <= DSC_BOOT;
               end
            end
            default: begin
               state <= DSC_BOOT;
               por_cnt <= POR_CNT_RST;
            end
         endcase
      end
   end

   // Interface choice is taken once; key resets do not retake it
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         iface_taken <= 1'b0;
         iface_i2c <= 1'b0;
      end else if (!iface_taken && state == DSC_BOOT &&
                   por_cnt == POR_LAST) begin
         iface_taken <= 1'b1;
         iface_i2c <= ifsel_s;
      end
   end

   // Configuration registers, defaults forced through the boot window
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_cfg <= SYNC_CFG_RST;
         power_setup_reg <= POWER_RST;
         amplification_ctl_reg <= GAIN_RST;
      end else if (!running) begin
         sync_cfg <= SYNC_CFG_RST;
         power_setup_reg <= POWER_RST;
         amplification_ctl_reg <= GAIN_RST;
      end else if (wr && hit_sync) begin
         sync_cfg <= wdata;
      end else if (wr && hit_power) begin
         power_setup_reg <= wdata;
      end else if (wr && hit_gain) begin
         amplification_ctl_reg <= wdata;
      end
   end

   // Channel buffers follow every write; reads never see active values
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         buf_a <= ZERO_CODE;
         buf_b <= ZERO_CODE;
      end else if (!running) begin
         buf_a <= reset_trim;
         buf_b <= reset_trim;
      end else begin
         if (wr_a) begin
            buf_a <= wcode;
         end
         if (wr_b) begin
            buf_b <= wcode;
         end
      end
   end

   // Active registers: immediate, or on the load trigger when deferred
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         active_a <= ZERO_CODE;
         active_b <= ZERO_CODE;
      end else if (!running) begin
         active_a <= reset_trim;
         active_b <= reset_trim;
      end else if (load_kick) begin
         active_a <= buf_a;
         active_b <= buf_b;
      end else begin
         if (wr_a && !deferred) begin
            active_a <= wcode;
         end
         if (wr_b && !deferred) begin
            active_b <= wcode;
         end
      end
   end

   // Registered outputs toward the analog section and the reader
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_code_a_o <= ZERO_CODE;
         out_code_b_o <= ZERO_CODE;
         output_amp_double_o <= GAIN_RST[1:0];
         ref_halve_o <= 1'b0;
         reference_off_o <= 1'b0;
         out_power_down_o <= 2'b00;
         ref_alarm_o <= 1'b0;
         init_busy_o <= 1'b1;
         iface_i2c_o <= 1'b0;
         rd_data_o <= READ_NONE;
         rd_valid_o <= 1'b0;
      end else begin
         out_code_a_o <= alarm ? ZERO_CODE : active_a;
         out_code_b_o <= alarm ? ZERO_CODE : active_b;
         output_amp_double_o <=
            {amplification_ctl_reg[GAIN_AMP_B_BIT],
             amplification_ctl_reg[GAIN_AMP_A_BIT]};
         ref_halve_o <= amplification_ctl_reg[GAIN_DIV_BIT];
         reference_off_o <= power_setup_reg[PWR_REF_BIT];
         out_power_down_o <= {power_setup_reg[PWR_OUT_B_BIT],
                              power_setup_reg[PWR_OUT_A_BIT]};
         ref_alarm_o <= alarm;
         init_busy_o <= ~running;
         iface_i2c_o <= iface_i2c;
         rd_valid_o <= rd;
         if (rd) begin
            rd_data_o <= rd_mux;
         end
      end
   end

   // Checks on the reference clock side
   boot_default_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (state == DSC_BOOT) |=>
         (buf_a == dsc_trim($past(rsel_s) ? MID_CODE : ZERO_CODE, RES_BITS)))
      else $error("buffer not at reset level during boot");

   code_trim_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (buf_a == dsc_trim(buf_a, RES_BITS)) &&
         (active_b == dsc_trim(active_b, RES_BITS)))
      else $error("code holds bits below resolution");

   div_out_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr && hit_gain && running) |-> ##2
         (ref_halve_o == $past(wdata[GAIN_DIV_BIT], 2)))
      else $error("divider output does not follow gain write");

   gain_boot_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      $rose(running) |=> (output_amp_double_o == GAIN_RST[1:0]))
      else $error("gain default not two after boot");

   immediate_upd_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr_a && !deferred && running) |-> ##2
         ($past(alarm) || out_code_a_o == $past(wcode, 2)))
      else $error("immediate write did not reach output");

   deferred_hold_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr_a && deferred && running) |=> $stable(active_a))
      else $error("deferred write changed active register");

   readback_buf_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (rd && hit_code_a) |=> (rd_valid_o && rd_data_o == $past(buf_a)))
      else $error("readback is not the buffer contents");

   alarm_zero_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      alarm |=> (out_code_a_o == ZERO_CODE && out_code_b_o == ZERO_CODE &&
                 ref_alarm_o))
      else $error("outputs not zero during reference alarm");

   boot_span_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (state == DSC_BOOT) |-> (por_cnt <= POR_LAST))
      else $error("boot counter beyond its window");

   key_reset_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      soft_rst |=> (state == DSC_BOOT) ##1 init_busy_o)
      else $error("key write did not start a reset");

   iface_hold_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      iface_taken |=> $stable(iface_i2c_o) || $past(!iface_taken, 2))
      else $error("interface choice changed after power up");

   commit_edge_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (commit_spi && wr_a) |=> (buf_a == $past(wcode)))
      else $error("committed frame did not load the buffer");

   load_kick_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      load_kick |=> (active_a == $past(buf_a) && active_b == $past(buf_b)))
      else $error("load trigger did not copy buffers");

   level_hold_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (running && !wr_a && !load_kick) |=> $stable(active_a))
      else $error("active code moved without a write");

   pwr_down_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr && hit_power) |-> ##2 (out_power_down_o ==
         $past({wdata[PWR_OUT_B_BIT], wdata[PWR_OUT_A_BIT]}, 2)))
      else $error("output power-down does not follow write");

   ref_off_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr && hit_power) |-> ##2
         (reference_off_o == $past(wdata[PWR_REF_BIT], 2)))
      else $error("reference power-down does not follow write");

   // Boot forces defaults every cycle, so a key reset cannot keep stale setup
   boot_cfg_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      !running |=> (sync_cfg == SYNC_CFG_RST &&
                    power_setup_reg == POWER_RST &&
                    amplification_ctl_reg == GAIN_RST))
      else $error("configuration not at defaults during boot");

endmodule : dsc_dual_dac_ctl

`default_nettype wire

// *** tb/dsc_host_model.sv ***
`default_nettype none

module dsc_host_model (
   output logic sclk_o,
   output logic frame_sel_b_o,
   output logic sdi_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // Clock idles high and stands still between frames
   initial begin
      sclk_o = 1'b1;
      frame_sel_b_o = 1'b1;
      sdi_o = 1'b0;
   end

   // Short counts only for abort tests; hp sets link speed
   task automatic send(input logic [23:0] w, input int n,
                       input realtime hp);
      frame_sel_b_o = 1'b0;
      #20;
      for (int i = 23; i > 23 - n; i--) begin
         sdi_o = w[i];
         #hp sclk_o = 1'b0;
         #hp sclk_o = 1'b1;
      end
      #20 frame_sel_b_o = 1'b1;
      // Released line shows the inverse, not a stale bit
      sdi_o = ~sdi_o;
      #1000;
   endtask : send
endmodule : dsc_host_model

`default_nettype wire

// *** tb/dsc_dual_dac_ctl_tb_top.sv ***
`default_nettype none

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end

module dsc_dual_dac_ctl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import dsc_pkg::*;

   logic ref_clk_i, rst_b_i, lvl, isel, ovr, stb;
   logic [23:0] word;
   wire logic sclk, fsb, sdi;
   logic [15:0] code_a, code_b, rd_data;
   logic [1:0] amp, pdn;
   logic halve, roff, alarm, busy, i2c, rdv;
   int fails = 0;
   int cmp_count = 0;
   int rd_cnt = 0;

   dsc_host_model host (.sclk_o(sclk), .frame_sel_b_o(fsb), .sdi_o(sdi));

   // 14-bit variant so trimming of low code bits is visible
   dsc_dual_dac_ctl #(.RES_BITS(14)) dut (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
      .frame_sel_b_i(fsb), .serial_data_in_i(sdi),
      .reset_level_select_i(lvl), .interface_select_i(isel),
      .ref_over_range_i(ovr), .i2c_wr_strobe_i(stb),
      .i2c_wr_word_i(word), .out_code_a_o(code_a),
      .out_code_b_o(code_b), .output_amp_double_o(amp),
      .ref_halve_o(halve), .reference_off_o(roff),
      .out_power_down_o(pdn), .ref_alarm_o(alarm),
      .init_busy_o(busy), .iface_i2c_o(i2c), .rd_data_o(rd_data),
      .rd_valid_o(rdv)
   );

   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i) begin
      if (rdv === 1'b1) begin
         rd_cnt++;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : tick

   task automatic end_sim;
      if (fails == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   task automatic wait_boot;
      for (int i = 0; i < 4000 && busy !== 1'b0; i++) begin
         tick(1);
      end
      if (busy !== 1'b0) begin
         `CHK(busy, 1'b0)
         end_sim();
      end
   endtask : wait_boot

   task automatic hard_rst(input logic l, input logic s);
      rst_b_i = 1'b0;
      lvl = l;
      isel = s;
      tick(4);
      rst_b_i = 1'b1;
      tick(2);
      wait_boot();
   endtask : hard_rst

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      host.send({1'b0, a, d}, 24, 62.5);
      tick(10);
   endtask : wr

   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      int n;
      n = rd_cnt;
      host.send({1'b1, a, 16'h0000}, 24, 62.5);
      tick(10);
      `CHK(rd_cnt, n + 1)
      `CHK(rd_data, e)
   endtask : rd

   task automatic t_defaults;
      `CHK(code_a, 16'h8000)
      `CHK(code_b, 16'h8000)
      `CHK(amp, 2'b11)
      `CHK(halve, 1'b0)
      `CHK(roff, 1'b0)
      `CHK(pdn, 2'b00)
      `CHK(i2c, 1'b0)
   endtask : t_defaults

   task automatic t_immediate;
      wr(REG_CODE_A, 16'h1234);
      `CHK(code_a, 16'h1234)
      `CHK(code_b, 16'h8000)
      host.send({1'b0, REG_CODE_B, 16'hffff}, 24, 62.5);
      tick(10);
      `CHK(code_b, 16'hfffc)
      rd(REG_CODE_A, 16'h1234);
      rd(7'h7f, 16'h0000);
   endtask : t_immediate

   task automatic t_deferred;
      wr(REG_SYNC_CFG, 16'h0001);
      wr(REG_CODE_A, 16'habcd);
      `CHK(code_a, 16'h1234)
      rd(REG_CODE_A, 16'habcc);
      wr(REG_KICK, 16'h0010);
      `CHK(code_a, 16'habcc)
      wr(REG_SYNC_CFG, 16'h0000);
   endtask : t_deferred

   task automatic t_short;
      host.send({1'b0, REG_CODE_A, 16'h5555}, 23, 62.5);
      tick(10);
      `CHK(code_a, 16'habcc)
      rd(REG_CODE_A, 16'habcc);
   endtask : t_short

   task automatic t_cfg;
      wr(REG_POWER, 16'h0103);
      `CHK(roff, 1'b1)
      `CHK(pdn, 2'b11)
      wr(REG_POWER, 16'h0000);
      wr(REG_GAIN, 16'h0100);
      `CHK(halve, 1'b1)
      `CHK(amp, 2'b00)
   endtask : t_cfg

   task automatic t_alarm;
      wr(REG_GAIN, 16'h0003);
      ovr = 1'b1;
      tick(10);
      `CHK(alarm, 1'b1)
      `CHK(code_a, 16'h0000)
      `CHK(code_b, 16'h0000)
      wr(REG_GAIN, 16'h0103);
      `CHK(alarm, 1'b0)
      `CHK(code_a, 16'habcc)
      ovr = 1'b0;
   endtask : t_alarm

   task automatic t_soft;
      lvl = 1'b0;
      wr(REG_KICK, 16'h1011);
      `CHK(busy, 1'b0)
      wr(REG_KICK, 16'h1010);
      `CHK(busy, 1'b1)
      wr(REG_CODE_A, 16'h7777);
      wait_boot();
      `CHK(code_a, 16'h0000)
      `CHK(amp, 2'b11)
      rd(REG_CODE_A, 16'h0000);
      word = {1'b0, REG_CODE_A, 16'h4444};
      stb = 1'b1;
      tick(1);
      stb = 1'b0;
      tick(4);
      `CHK(code_a, 16'h0000)
   endtask : t_soft

   task automatic t_i2c;
      hard_rst(1'b1, 1'b1);
      `CHK(i2c, 1'b1)
      wr(REG_CODE_A, 16'h1111);
      `CHK(code_a, 16'h8000)
      word = {1'b0, REG_CODE_A, 16'h4321};
      stb = 1'b1;
      tick(1);
      stb = 1'b0;
      `CHK(code_a, 16'h8000)
      tick(1);
      `CHK(code_a, 16'h4320)
   endtask : t_i2c

   initial begin
      rst_b_i = 1'b0;
      lvl = 1'b1;
      isel = 1'b0;
      ovr = 1'b0;
      stb = 1'b0;
      word = 24'h000000;
      hard_rst(1'b1, 1'b0);
      t_defaults();
      t_immediate();
      t_deferred();
      t_short();
      t_cfg();
      t_alarm();
      t_soft();
      t_i2c();
      end_sim();
   end
endmodule : dsc_dual_dac_ctl_tb_top

`default_nettype wire
